// File: rtl/rrcs_switch.sv
/*
 * Control logic of a dual-reference clock switch: failure watch, reference selection,
 * alarm clear, bypass and divider hold, with an APB register file and one interrupt.
 * Assumes all pins are asynchronous to pclk and toggle well below a quarter of its rate.
 */
// Design decisions made here: the register addresses and the APB interface to the registers.
// Notes on behaviour
// (RULE_01) Flag a reference stuck for one feedback period.
// (RULE_02) Alarm clear falling edge clears flags, selection.
// (RULE_03) Status low for reference 0, high for 1.
// (RULE_04) Primary select low picks 0, high picks 1.
// (RULE_05) Path enable low bypasses the PLL.
// (RULE_06) Divider hold low resets dividers, outputs low.
// (RULE_07) Manual override: reference always follows primary select.
// (RULE_08) Failure detection works in both override modes.
// (RULE_09) Automatic: first failure latches, switches to other.
// (RULE_10) Flags and selection persist until alarm clear; the selection here follows primary select while manual override is high.
// (RULE_11) Both bad after clear: both flags, select 0.
// (RULE_12) No flags set: selection follows primary select.
// (RULE_13) After switch, new falling edge, then align pair.
// (RULE_14) Controller starts up via override, lock wait, clear.
// (RULE_15) Per-input edge watchers against feedback periods.
// (RULE_16) Synchronise alarm clear; clear pulse lasts one cycle.
`timescale 1ns/1ps
`include "rrcs_map.svh"
module rrcs_switch (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RRCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference and feedback clocks
    input wire logic ref_clock_0,
    input wire logic ref_clock_1,
    input wire logic feedback_clock,
    // Board control pins
    input wire logic primary_select,
    input wire logic manual_override,
    input wire logic alarm_clear,
    input wire logic pll_path_enable,
    input wire logic divider_hold_n,
    // Status and control outputs
    output logic input_fail_flag_0,
    output logic input_fail_flag_1,
    output logic ref_select_status,
    output logic pll_ref_select,
    output logic pll_bypass,
    output logic divider_reset,
    output logic slew_align,
    output logic irq
);
    localparam int NPIN = `RRCS_PIN_N;

    function automatic logic rises(input logic now, input logic was);
        return now & ~was;
    endfunction

    function automatic logic falls(input logic now, input logic was);
        return ~now & was;
    endfunction

    function automatic logic hit(input logic [`RRCS_ADDR_W-1:0] a,
                                 input logic [`RRCS_ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Pin synchronisers: three stages, the filtered value moves only when stages two and three agree.
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
    logic [NPIN-1:0] s1_d, s2_d, s3_d, filt_d, prev_d;

    assign pins = {divider_hold_n, pll_path_enable, alarm_clear, manual_override,
                   primary_select, feedback_clock, ref_clock_1, ref_clock_0};

    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
        filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        prev_d = filt_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= `RRCS_PIN_RST;
            s2_q <= `RRCS_PIN_RST;
            s3_q <= `RRCS_PIN_RST;
            filt_q <= `RRCS_PIN_RST;
            prev_q <= `RRCS_PIN_RST;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
            prev_q <= prev_d;
        end
    end

    logic prim_f, man_f, pllen_f, divh_f;
    logic r0_rise, r0_fall, r1_rise, r1_fall, fb_rise, fb_fall, alarm_fall;
    logic soft_clr_q, soft_clr_d;
    logic clr_pulse;

    assign prim_f = filt_q[`RRCS_PIN_PRIM];
    assign man_f = filt_q[`RRCS_PIN_MAN];
    assign pllen_f = filt_q[`RRCS_PIN_PLLEN];
    assign divh_f = filt_q[`RRCS_PIN_DIVH];
    assign r0_rise = rises(filt_q[`RRCS_PIN_REF0], prev_q[`RRCS_PIN_REF0]);
    assign r0_fall = falls(filt_q[`RRCS_PIN_REF0], prev_q[`RRCS_PIN_REF0]);
    assign r1_rise = rises(filt_q[`RRCS_PIN_REF1], prev_q[`RRCS_PIN_REF1]);
    assign r1_fall = falls(filt_q[`RRCS_PIN_REF1], prev_q[`RRCS_PIN_REF1]);
    assign fb_rise = rises(filt_q[`RRCS_PIN_FB], prev_q[`RRCS_PIN_FB]);
    assign fb_fall = falls(filt_q[`RRCS_PIN_FB], prev_q[`RRCS_PIN_FB]);
    // Edge taken on the filtered level, so one falling edge gives exactly one cycle.
    assign alarm_fall = falls(filt_q[`RRCS_PIN_ALARM], prev_q[`RRCS_PIN_ALARM]); // see (RULE_16)
    assign clr_pulse = alarm_fall | soft_clr_q; // see (RULE_02)

    // Edge watchers run whatever the override pin says.
    rrcs_watch_if w0 ();
    rrcs_watch_if w1 ();

    assign w0.clear = clr_pulse;
    assign w0.ref_edge = r0_rise | r0_fall;
    assign w0.fb_rise = fb_rise; // see (RULE_08)
    assign w0.fb_fall = fb_fall;
    assign w1.clear = clr_pulse;
    assign w1.ref_edge = r1_rise | r1_fall;
    assign w1.fb_rise = fb_rise; // see (RULE_08)
    assign w1.fb_fall = fb_fall;

    rrcs_edge_watch u_watch0 (
        .pclk(pclk),
        .presetn(presetn),
        .wif(w0.watch)
    );

    rrcs_edge_watch u_watch1 (
        .pclk(pclk),
        .presetn(presetn),
        .wif(w1.watch)
    );

    // Failure latches and reference selection.
    logic fail0_q, fail0_d, fail1_q, fail1_d, sel_q, sel_d;
    logic switch_ev;

    always_comb begin
        fail0_d = fail0_q | w0.fail; // see (RULE_10)
        fail1_d = fail1_q | w1.fail;
        if (clr_pulse) begin
            // A failure seen in the clearing cycle still sets its flag.
            fail0_d = w0.fail; // see (RULE_02)
            fail1_d = w1.fail;
        end
        sel_d = sel_q;
        if (clr_pulse || man_f) begin
            sel_d = prim_f; // see (RULE_07) (RULE_10) (RULE_04)
        end else if (!fail0_q && !fail1_q) begin
            if (w0.fail && w1.fail) begin
                sel_d = 1'b0; // see (RULE_11)
            end else if (w0.fail && !sel_q) begin
                sel_d = 1'b1; // see (RULE_09)
            end else if (w1.fail && sel_q) begin
                sel_d = 1'b0; // see (RULE_09)
            end else begin
                sel_d = prim_f; // see (RULE_12)
            end
        end
    end

    assign switch_ev = sel_d != sel_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail0_q <= 1'b0;
            fail1_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            fail0_q <= fail0_d;
            fail1_q <= fail1_d;
            sel_q <= sel_d;
        end
    end

    // Alignment sequence: the PLL mux moves only on a falling edge of the new reference,
    // so the reference never carries a runt pulse into the phase detector.
    rrcs_pkg::rrcs_align_e align_q, align_d;
    rrcs_pkg::rrcs_pair_s pair_q, pair_d;
    logic active_q, active_d, slew_q, slew_d;
    logic new_fall, new_rise;

    assign new_fall = sel_q ? r1_fall : r0_fall;
    assign new_rise = sel_q ? r1_rise : r0_rise;

    always_comb begin
        align_d = align_q;
        pair_d = pair_q;
        active_d = active_q;
        slew_d = 1'b0;
        unique case (align_q)
            rrcs_pkg::align_idle: begin
                pair_d = '0;
            end
            rrcs_pkg::align_wait_fall: begin
                if (new_fall) begin
                    active_d = sel_q; // see (RULE_13)
                    pair_d = '0;
                    align_d = rrcs_pkg::align_wait_pair;
                end
            end
            rrcs_pkg::align_wait_pair: begin
                pair_d.fb_seen = pair_q.fb_seen | fb_rise;
                pair_d.ref_seen = pair_q.ref_seen | new_rise;
                if (pair_d.fb_seen && pair_d.ref_seen) begin
                    slew_d = 1'b1; // see (RULE_13)
                    align_d = rrcs_pkg::align_idle;
                end
            end
        endcase
        if (switch_ev) begin
            // A fresh switch restarts the sequence for the newest reference.
            align_d = rrcs_pkg::align_wait_fall;
            slew_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            align_q <= rrcs_pkg::align_idle;
            pair_q <= '0;
            active_q <= 1'b0;
            slew_q <= 1'b0;
        end else begin
            align_q <= align_d;
            pair_q <= pair_d;
            active_q <= active_d;
            slew_q <= slew_d;
        end
    end

    // Bypass and divider hold are plain registered inversions of the filtered pins.
    logic bypass_q, bypass_d, divrst_q, divrst_d;

    always_comb begin
        bypass_d = ~pllen_f; // see (RULE_05)
        divrst_d = ~divh_f; // see (RULE_06)
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bypass_q <= 1'b0;
            divrst_q <= 1'b0;
        end else begin
            bypass_q <= bypass_d;
            divrst_q <= divrst_d;
        end
    end

    // APB slave: no wait states; read data and error are captured in the setup cycle.
    logic setup, access_wr;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    rrcs_pkg::rrcs_ev_t int_st_q, int_st_d, int_en_q, int_en_d, events;

    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite;

    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            rdata_d = 32'h00000000;
            err_d = 1'b0;
            if (hit(paddr, `RRCS_OFF_STATE) && !pwrite) begin
                rdata_d[`RRCS_ST_FAIL0] = fail0_q;
                rdata_d[`RRCS_ST_FAIL1] = fail1_q;
                rdata_d[`RRCS_ST_SEL] = sel_q;
                rdata_d[`RRCS_ST_ACTIVE] = active_q;
                rdata_d[`RRCS_ST_ALIGN_BUSY] = align_q != rrcs_pkg::align_idle;
                rdata_d[`RRCS_ST_MANUAL] = man_f;
                rdata_d[`RRCS_ST_PRIMARY] = prim_f;
            end else if (hit(paddr, `RRCS_OFF_INT_STATUS) && !pwrite) begin
                rdata_d[`RRCS_EV_W-1:0] = int_st_q;
            end else if (hit(paddr, `RRCS_OFF_INT_ENABLE)) begin
                rdata_d[`RRCS_EV_W-1:0] = int_en_q;
            end else if (hit(paddr, `RRCS_OFF_INT_CLEAR) || hit(paddr, `RRCS_OFF_CTRL)) begin
                err_d = !pwrite;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    always_comb begin
        events = '0;
        events[`RRCS_EV_FAIL0] = fail0_d & ~fail0_q;
        events[`RRCS_EV_FAIL1] = fail1_d & ~fail1_q;
        events[`RRCS_EV_SWITCH] = switch_ev;
        events[`RRCS_EV_ALIGN] = slew_d;
        int_en_d = int_en_q;
        int_st_d = int_st_q;
        soft_clr_d = 1'b0;
        if (access_wr && hit(paddr, `RRCS_OFF_INT_ENABLE)) begin
            int_en_d = pwdata[`RRCS_EV_W-1:0];
        end
        if (access_wr && hit(paddr, `RRCS_OFF_INT_CLEAR)) begin
            int_st_d = int_st_q & ~pwdata[`RRCS_EV_W-1:0];
        end
        if (access_wr && hit(paddr, `RRCS_OFF_CTRL)) begin
            soft_clr_d = pwdata[`RRCS_CTRL_SOFT_CLEAR];
        end
        // Set wins over a clear written in the same cycle.
        int_st_d = int_st_d | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
            int_st_q <= '0;
            int_en_q <= `RRCS_INT_EN_RST;
            soft_clr_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
            int_st_q <= int_st_d;
            int_en_q <= int_en_d;
            soft_clr_q <= soft_clr_d;
        end
    end

    assign pready = psel & penable;
    assign prdata = rdata_q;
    assign pslverr = psel & penable & err_q;
    assign irq = |(int_st_q & int_en_q);

    assign input_fail_flag_0 = fail0_q;
    assign input_fail_flag_1 = fail1_q;
    assign ref_select_status = sel_q; // see (RULE_03)
    assign pll_ref_select = active_q;
    assign pll_bypass = bypass_q;
    assign divider_reset = divrst_q;
    assign slew_align = slew_q;

    clear_once_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_16)
        alarm_fall |=> !alarm_fall [*2])
        else $error("alarm clear produced more than one pulse");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_10)
        fail0_q && !clr_pulse |=> fail0_q)
        else $error("failure flag 0 dropped without alarm clear");
    clear_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_02)
        clr_pulse && !w0.fail && !w1.fail |=> !fail0_q && !fail1_q && sel_q == $past(prim_f))
        else $error("alarm clear did not clear flags and selection");
    manual_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_07)
        man_f |=> sel_q == $past(prim_f))
        else $error("manual override selection differs from primary select");
    auto_switch_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_09)
        !man_f && !clr_pulse && !fail0_q && !fail1_q && !sel_q && w0.fail && !w1.fail
        |=> sel_q && fail0_q ##0 ref_select_status)
        else $error("failed reference 0 did not switch to reference 1");
    both_bad_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_11)
        !man_f && !clr_pulse && !fail0_q && !fail1_q && w0.fail && w1.fail
        |=> !sel_q && fail0_q && fail1_q)
        else $error("both failed references did not select reference 0");
    follow_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_12)
        !fail0_q && !fail1_q && !w0.fail && !w1.fail |=> sel_q == $past(prim_f))
        else $error("selection did not follow primary select");
    sticky_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_10)
        !man_f && !clr_pulse && (fail0_q || fail1_q) |=> $stable(sel_q))
        else $error("latched selection changed without alarm clear");
    align_start_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_13)
        switch_ev |=> align_q == rrcs_pkg::align_wait_fall && !slew_align)
        else $error("switch did not start the alignment sequence");
    mux_move_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_13)
        $changed(active_q) |-> $past(align_q) == rrcs_pkg::align_wait_fall && $past(new_fall))
        else $error("reference mux moved outside a falling edge");
    pins_out_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_05) (RULE_06)
        !pllen_f && !divh_f |=> pll_bypass && divider_reset)
        else $error("bypass or divider hold not applied");

    auto_switch_c: cover property (@(posedge pclk) disable iff (!presetn)
        !man_f && switch_ev && (w0.fail || w1.fail));
    both_bad_c: cover property (@(posedge pclk) disable iff (!presetn) w0.fail && w1.fail);
    alarm_clear_c: cover property (@(posedge pclk) disable iff (!presetn) alarm_fall && fail0_q);
    align_done_c: cover property (@(posedge pclk) disable iff (!presetn) slew_align);
endmodule

// File: rtl/rrcs_map.svh
/*
 * Register offsets, bit positions, reset values and pin indices of the reference clock switch.
 * Assumes a 12-bit APB byte address with one aligned 32-bit word per register.
 */
`ifndef RRCS_MAP_SVH
`define RRCS_MAP_SVH

`define RRCS_ADDR_W 12
`define RRCS_OFF_STATE 12'h000
`define RRCS_OFF_INT_STATUS 12'h004
`define RRCS_OFF_INT_CLEAR 12'h008
`define RRCS_OFF_INT_ENABLE 12'h00C
`define RRCS_OFF_CTRL 12'h010

`define RRCS_ST_FAIL0 0
`define RRCS_ST_FAIL1 1
`define RRCS_ST_SEL 2
`define RRCS_ST_ACTIVE 3
`define RRCS_ST_ALIGN_BUSY 4
`define RRCS_ST_MANUAL 5
`define RRCS_ST_PRIMARY 6

`define RRCS_EV_FAIL0 0
`define RRCS_EV_FAIL1 1
`define RRCS_EV_SWITCH 2
`define RRCS_EV_ALIGN 3
`define RRCS_EV_W 4
`define RRCS_INT_EN_RST 4'h0

`define RRCS_CTRL_SOFT_CLEAR 0

`define RRCS_PIN_REF0 0
`define RRCS_PIN_REF1 1
`define RRCS_PIN_FB 2
`define RRCS_PIN_PRIM 3
`define RRCS_PIN_MAN 4
`define RRCS_PIN_ALARM 5
`define RRCS_PIN_PLLEN 6
`define RRCS_PIN_DIVH 7
`define RRCS_PIN_N 8
`define RRCS_PIN_RST 8'hE0

`endif

// File: rtl/rrcs_pkg.sv
/*
 * Types shared by the reference clock switch modules.
 * Assumes the constants of rrcs_map.svh are included where numbers are needed.
 */
package rrcs_pkg;

    typedef enum logic [1:0] {
        align_idle = 2'b00,
        align_wait_fall = 2'b01,
        align_wait_pair = 2'b10
    } rrcs_align_e;

    typedef struct packed {
        logic fb_seen;
        logic ref_seen;
    } rrcs_pair_s;

    typedef logic [3:0] rrcs_ev_t;

endpackage

// File: rtl/rrcs_watch_if.sv
/*
 * Signals between the switch controller and one reference edge watcher.
 * Assumes both ends run on the same pclk; all members are one-cycle pulses.
 */
`timescale 1ns/1ps
interface rrcs_watch_if;
    logic clear;
    logic ref_edge;
    logic fb_rise;
    logic fb_fall;
    logic fail;

    modport ctl (output clear, output ref_edge, output fb_rise, output fb_fall, input fail);
    modport watch (input clear, input ref_edge, input fb_rise, input fb_fall, output fail);
endinterface

// File: rtl/rrcs_edge_watch.sv
/*
 * Edge watcher for one reference clock, measured against the feedback clock.
 * Assumes synchronised, edge-detected pulses on pclk from the controller.
 */
`timescale 1ns/1ps
module rrcs_edge_watch (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controller side
    rrcs_watch_if.watch wif
);
    logic armed_r_q, armed_r_d, armed_f_q, armed_f_d;
    logic seen_r_q, seen_r_d, seen_f_q, seen_f_d;
    logic fail_q, fail_d;

    // Two windows, rising to rising and falling to falling; either empty window is a failure.
    // A window only counts once armed by a first feedback edge, so a full period is always seen.
    always_comb begin
        armed_r_d = armed_r_q;
        armed_f_d = armed_f_q;
        seen_r_d = seen_r_q | wif.ref_edge;
        seen_f_d = seen_f_q | wif.ref_edge;
        fail_d = 1'b0;
        if (wif.fb_rise) begin
            if (armed_r_q && !seen_r_q && !wif.ref_edge) begin
                fail_d = 1'b1; // see (RULE_01) (RULE_15)
            end
            armed_r_d = 1'b1;
            seen_r_d = 1'b0;
        end
        if (wif.fb_fall) begin
            if (armed_f_q && !seen_f_q && !wif.ref_edge) begin
                fail_d = 1'b1; // see (RULE_01) (RULE_15)
            end
            armed_f_d = 1'b1;
            seen_f_d = 1'b0;
        end
        if (wif.clear) begin
            armed_r_d = 1'b0;
            armed_f_d = 1'b0;
            seen_r_d = 1'b0;
            seen_f_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r_q <= 1'b0;
            armed_f_q <= 1'b0;
            seen_r_q <= 1'b0;
            seen_f_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            armed_r_q <= armed_r_d;
            armed_f_q <= armed_f_d;
            seen_r_q <= seen_r_d;
            seen_f_q <= seen_f_d;
            fail_q <= fail_d;
        end
    end

    assign wif.fail = fail_q;

    empty_window_a: assert property (@(posedge pclk) disable iff (!presetn) // see (RULE_15)
        wif.fb_rise && armed_r_q && !seen_r_q && !wif.ref_edge |=> wif.fail)
        else $error("empty feedback window did not flag a failure");
endmodule

// File: tb/rrcs_partner.sv
/*
 * Model of the two reference sources and the feedback clock seen by the switch.
 * Assumes the bench stops a source to fake a failure; a stopped source holds its level.
 */
`timescale 1ns/1ps
module rrcs_partner #(
    parameter int HALF_NS = 80
) (
    // Fault controls from the bench
    input wire logic stop_0,
    input wire logic stop_1,
    // Clocks towards the switch
    output logic ref_clock_0,
    output logic ref_clock_1,
    output logic feedback_clock
);
    // The three clocks share one rate but not one phase, as real sources would.
    initial begin
        feedback_clock = 1'b0;
        forever #(HALF_NS) feedback_clock = ~feedback_clock;
    end
    initial begin
        ref_clock_0 = 1'b0;
        #(13);
        forever #(HALF_NS) if (!stop_0) ref_clock_0 = ~ref_clock_0;
    end
    initial begin
        ref_clock_1 = 1'b0;
        #(37);
        forever #(HALF_NS) if (!stop_1) ref_clock_1 = ~ref_clock_1;
    end
endmodule

// File: tb/rrcs_switch_tb.sv
/*
 * Self-checking bench of the reference clock switch: APB tasks plus pin sequences.
 * Assumes the partner model makes the clocks and the bench plays the board controller.
 */
`timescale 1ns/1ps
`include "rrcs_map.svh"
module rrcs_switch_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ref_clock_0, ref_clock_1, feedback_clock, stop_0, stop_1;
    logic primary_select, manual_override, alarm_clear, pll_path_enable, divider_hold_n;
    logic input_fail_flag_0, input_fail_flag_1, ref_select_status, pll_ref_select;
    logic pll_bypass, divider_reset, slew_align, er, slew_seen;
    int n_mismatch = 0;
    int compares = 0;

    rrcs_partner rrcs_partner_inst (.stop_0(stop_0), .stop_1(stop_1),
        .ref_clock_0(ref_clock_0), .ref_clock_1(ref_clock_1), .feedback_clock(feedback_clock));
    rrcs_switch rrcs_switch_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clock_0(ref_clock_0),
        .ref_clock_1(ref_clock_1), .feedback_clock(feedback_clock),
        .primary_select(primary_select), .manual_override(manual_override),
        .alarm_clear(alarm_clear), .pll_path_enable(pll_path_enable),
        .divider_hold_n(divider_hold_n), .input_fail_flag_0(input_fail_flag_0),
        .input_fail_flag_1(input_fail_flag_1), .ref_select_status(ref_select_status),
        .pll_ref_select(pll_ref_select), .pll_bypass(pll_bypass),
        .divider_reset(divider_reset), .slew_align(slew_align), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) if (slew_align === 1'b1) slew_seen <= 1'b1;

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wcyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps a following call from driving psel twice in one time step.
        @(posedge pclk);
    endtask

    // A falling edge on alarm_clear, each level held long enough to pass the filter.
    task automatic alarm_pulse();
        alarm_clear <= 1'b0;
        wcyc(4);
        alarm_clear <= 1'b1;
        wcyc(8);
    endtask

    task automatic flags(input logic [2:0] exp);
        chk({input_fail_flag_1, input_fail_flag_0, ref_select_status}, exp);
    endtask

    initial begin
        #200us;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {stop_0, stop_1, primary_select, manual_override, slew_seen} = '0;
        {alarm_clear, pll_path_enable, divider_hold_n} = 3'b111;
        wcyc(2);
        presetn <= 1'b1;
        wcyc(8);
        manual_override <= 1'b1;
        wcyc(40);
        alarm_pulse();
        manual_override <= 1'b0;
        wcyc(8);
        flags(3'b000);
        primary_select <= 1'b1;
        wcyc(8);
        flags(3'b001);
        primary_select <= 1'b0;
        wcyc(8);
        flags(3'b000);
        pll_path_enable <= 1'b0;
        divider_hold_n <= 1'b0;
        wcyc(8);
        chk({pll_bypass, divider_reset}, 2'b11);
        pll_path_enable <= 1'b1;
        divider_hold_n <= 1'b1;
        wcyc(8);
        chk({pll_bypass, divider_reset}, 2'b00);
        apb(1'b1, `RRCS_OFF_INT_ENABLE, 32'h0000_0001);
        slew_seen <= 1'b0;
        stop_0 <= 1'b1;
        // Worst case is detection, then a falling and a rising edge of the new reference.
        wcyc(80);
        flags(3'b011);
        chk(pll_ref_select, 1'b1);
        chk(slew_seen, 1'b1);
        chk(irq, 1'b1);
        apb(1'b0, `RRCS_OFF_STATE, 32'h0);
        chk(rd[2:0], 3'b101);
        apb(1'b0, `RRCS_OFF_INT_STATUS, 32'h0);
        chk(rd[3:0], 4'hD);
        apb(1'b1, `RRCS_OFF_INT_CLEAR, 32'h0000_000F);
        wcyc(2);
        chk(irq, 1'b0);
        // A recovered source must not release the latched flag on its own.
        stop_0 <= 1'b0;
        primary_select <= 1'b1;
        wcyc(8);
        primary_select <= 1'b0;
        wcyc(8);
        flags(3'b011);
        alarm_pulse();
        flags(3'b000);
        stop_0 <= 1'b1;
        stop_1 <= 1'b1;
        wcyc(60);
        // Keep the clear pulse off the cycles in which stuck watchers report.
        @(posedge feedback_clock);
        wcyc(3);
        primary_select <= 1'b1;
        alarm_pulse();
        wcyc(60);
        flags(3'b110);
        {stop_0, stop_1} <= 2'b00;
        manual_override <= 1'b1;
        wcyc(20);
        alarm_pulse();
        stop_1 <= 1'b1;
        wcyc(60);
        flags(3'b101);
        stop_1 <= 1'b0;
        wcyc(20);
        apb(1'b1, `RRCS_OFF_CTRL, 32'h0000_0001);
        wcyc(1);
        flags(3'b001);
        apb(1'b0, 12'h014, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, `RRCS_OFF_INT_CLEAR, 32'h0);
        chk(er, 1'b1);
        end_of_test();
    end
endmodule
